// >>> hdl/cts_consts.vh
`ifndef CTS_CONSTS_VH
`define CTS_CONSTS_VH
// APB byte offsets
`define CTS_OFF_CTRL1      12'h000
`define CTS_OFF_CTRL2      12'h004
`define CTS_OFF_TMR_CTRL   12'h008
`define CTS_OFF_SMALL_CNT  12'h00C
`define CTS_OFF_WIDE_CNT   12'h010
`define CTS_OFF_STATUS     12'h014
// sense_control_first fields
`define CTS_C1_ENABLE      7
`define CTS_C1_REFMODE     6
`define CTS_C1_RNG_HI      3
`define CTS_C1_RNG_LO      2
`define CTS_C1_STATE       1
`define CTS_C1_EXTSEL      0
// timer control fields
`define CTS_TC_SMALL_CS    0
`define CTS_TC_WIDE_CS_LO  1
`define CTS_TC_WIDE_CS_HI  2
`define CTS_TC_WIDE_ON     3
`define CTS_TC_WIDE_GE     4
`define CTS_TC_SMALL_CLR   5
`define CTS_TC_WIDE_CLR    6
// Reset values
`define CTS_RST_CTRL1      8'h00
`define CTS_RST_CTRL2      4'h0
`define CTS_RST_TMR_CTRL   5'h00
// Encodings
`define CTS_RNG_NOISE_OFF  2'h0
`define CTS_WIDE_CS_OSC    2'h3
`endif

// >>> hdl/cts_sense.v
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`include "cts_consts.vh"

// Notes on behaviour
// - Sixteen pads; channel field connects exactly one pad to the oscillator.
// - Changing channel while enabled moves the oscillator to the new pad.
// - Read-only bit shows oscillator sourcing or sinking.
// - Reference bit 1: DAC low, fixed reference high; 0: ground and supply.
// - Range 01/10/11 low/medium/high; 00 noise (high) or off (low).
// - Noise mode stops pad current, comparators stay active.
// - In noise mode pad noise toggles comparator output.
// - Oscillator clocks the small or the wide gated timer.
// - Ext select set and small clock-source clear: small timer uses oscillator.
// - Wide clock-source 11: wide timer uses oscillator.
// - Wide timer off when on=0, free when gate off, gated otherwise.
// - Oscillator keeps running while enabled, even in sleep.
// - Small timer stops in sleep.
module cts_sense #(
	parameter NUM_PADS = 16,
	parameter CH_W     = 4
) (
	input  wire                mclk,
	input  wire                srst,
	input  wire                psel,
	input  wire                penable,
	input  wire                pwrite,
	input  wire [11:0]         paddr,
	input  wire [31:0]         pwdata,
	output reg  [31:0]         prdata,
	output reg                 pready,
	output reg                 pslverr,
	input  wire                cpu_sleep,
	input  wire                comp_upper,
	input  wire                comp_lower,
	input  wire                small_ext_pin,
	input  wire                wide_gate_in,
	output reg  [NUM_PADS-1:0] pad_connect,
	output reg                 osc_enable,
	output reg                 source_on,
	output reg                 sink_on,
	output reg                 comparators_on,
	output reg                 ref_mode_variable,
	output reg  [1:0]          current_range_out,
	output reg                 small_timer_tick,
	output reg                 wide_timer_tick,
	output reg                 small_overflow
);
	//--------------------------------------------------
	// Registers
	//--------------------------------------------------
	reg            sense_unit_enable;
	reg            reference_mode_bit;
	reg [1:0]      current_range_field;
	reg            small_timer_ext_source_sel;
	reg [CH_W-1:0] sense_channel_select;
	reg            small_timer_clock_source;
	reg [1:0]      wide_timer_clock_source;
	reg            wide_timer_on;
	reg            wide_timer_gate_enable;
	reg            osc_source_sink_state;
	reg [7:0]      small_cnt;
	reg [15:0]     wide_cnt;
	reg            period_done;

	localparam [7:0]      RST_C1 = `CTS_RST_CTRL1;
	localparam [CH_W-1:0] RST_C2 = `CTS_RST_CTRL2;
	localparam [4:0]      RST_TC = `CTS_RST_TMR_CTRL;

	wire up_s;
	wire lo_s;
	wire pin_s;
	wire gate_s;

	cts_sync u_up (
		.mclk (mclk),
		.srst (srst),
		.din  (comp_upper),
		.dout (up_s)
	);
	cts_sync u_lo (
		.mclk (mclk),
		.srst (srst),
		.din  (comp_lower),
		.dout (lo_s)
	);
	cts_sync u_pin (
		.mclk (mclk),
		.srst (srst),
		.din  (small_ext_pin),
		.dout (pin_s)
	);
	cts_sync u_gate (
		.mclk (mclk),
		.srst (srst),
		.din  (wide_gate_in),
		.dout (gate_s)
	);

	wire noise_mode = reference_mode_bit &&
		(current_range_field == `CTS_RNG_NOISE_OFF);
	wire osc_off    = !reference_mode_bit &&
		(current_range_field == `CTS_RNG_NOISE_OFF);
	// Sleep is deliberately not a term here
	wire osc_run    = sense_unit_enable && !osc_off;
	wire small_from_osc = small_timer_ext_source_sel && !small_timer_clock_source;
	wire wide_from_osc  = (wide_timer_clock_source == `CTS_WIDE_CS_OSC);

	//--------------------------------------------------
	// Oscillator state tracking
	//--------------------------------------------------
	// Comparator crossings flip the phase; noise can still toggle it.
	reg            next_state;
	reg            next_done;
	always @* begin
		next_state = osc_source_sink_state;
		next_done  = 1'b0;
		if (osc_run || noise_mode) begin
			if (osc_source_sink_state && up_s)
				next_state = 1'b0;
			else if (!osc_source_sink_state && lo_s) begin
				next_state = 1'b1;
				// Sink phase ended: one whole period has elapsed
				next_done  = 1'b1;
			end
		end
	end

	always @(posedge mclk) begin
		if (srst) begin
			osc_source_sink_state <= 1'b1;
			period_done           <= 1'b0;
		end else begin
			osc_source_sink_state <= (sense_unit_enable) ? next_state : 1'b1;
			period_done           <= sense_unit_enable & next_done;
		end
	end

	//--------------------------------------------------
	// Analogue control outputs
	//--------------------------------------------------
	integer i;
	always @(posedge mclk) begin
		if (srst) begin
			pad_connect       <= {NUM_PADS{1'b0}};
			osc_enable        <= 1'b0;
			source_on         <= 1'b0;
			sink_on           <= 1'b0;
			comparators_on    <= 1'b0;
			ref_mode_variable <= 1'b0;
			current_range_out <= 2'h0;
		end else begin
			for (i = 0; i < NUM_PADS; i = i + 1)
				pad_connect[i] <= sense_unit_enable &&
					(sense_channel_select == i[CH_W-1:0]);
			osc_enable        <= osc_run;
			// Noise mode: no pad current, comparators kept alive
			source_on         <= osc_run && !noise_mode && osc_source_sink_state;
			sink_on           <= osc_run && !noise_mode && !osc_source_sink_state;
			comparators_on    <= osc_run;
			ref_mode_variable <= reference_mode_bit;
			current_range_out <= current_range_field;
		end
	end

	//--------------------------------------------------
	// Timers
	//--------------------------------------------------
	reg pin_q;
	wire pin_rise   = pin_s && !pin_q;
	wire small_clk  = small_from_osc ? period_done :
		(small_timer_clock_source ? pin_rise : 1'b0);
	wire small_inc  = small_clk && !cpu_sleep;
	wire wide_run   = wide_timer_on && (!wide_timer_gate_enable || gate_s);
	wire wide_inc   = wide_from_osc && period_done && wide_run;
	wire apb_wr     = psel && penable && pwrite;
	wire wr_tc      = apb_wr && (paddr == `CTS_OFF_TMR_CTRL);

	always @(posedge mclk) begin
		if (srst) begin
			pin_q            <= 1'b0;
			small_cnt        <= 8'h00;
			wide_cnt         <= 16'h0000;
			small_timer_tick <= 1'b0;
			wide_timer_tick  <= 1'b0;
			small_overflow   <= 1'b0;
		end else begin
			pin_q            <= pin_s;
			small_timer_tick <= small_inc;
			wide_timer_tick  <= wide_inc;
			small_overflow   <= small_inc && (small_cnt == 8'hFF);
			if (wr_tc && pwdata[`CTS_TC_SMALL_CLR])
				small_cnt <= 8'h00;
			else if (small_inc)
				small_cnt <= small_cnt + 8'h01;
			if (wr_tc && pwdata[`CTS_TC_WIDE_CLR])
				wide_cnt <= 16'h0000;
			else if (wide_inc)
				wide_cnt <= wide_cnt + 16'h0001;
		end
	end

	//--------------------------------------------------
	// APB slave, zero wait states
	//--------------------------------------------------
	wire known = (paddr == `CTS_OFF_CTRL1) || (paddr == `CTS_OFF_CTRL2) ||
		(paddr == `CTS_OFF_TMR_CTRL) || (paddr == `CTS_OFF_SMALL_CNT) ||
		(paddr == `CTS_OFF_WIDE_CNT) || (paddr == `CTS_OFF_STATUS);
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		case (paddr)
		`CTS_OFF_CTRL1: begin
			rd_mux[`CTS_C1_ENABLE]  = sense_unit_enable;
			rd_mux[`CTS_C1_REFMODE] = reference_mode_bit;
			rd_mux[`CTS_C1_RNG_HI:`CTS_C1_RNG_LO] = current_range_field;
			rd_mux[`CTS_C1_STATE]   = osc_source_sink_state;
			rd_mux[`CTS_C1_EXTSEL]  = small_timer_ext_source_sel;
		end
		`CTS_OFF_CTRL2:     rd_mux[CH_W-1:0] = sense_channel_select;
		`CTS_OFF_TMR_CTRL: begin
			rd_mux[`CTS_TC_SMALL_CS] = small_timer_clock_source;
			rd_mux[`CTS_TC_WIDE_CS_HI:`CTS_TC_WIDE_CS_LO] = wide_timer_clock_source;
			rd_mux[`CTS_TC_WIDE_ON]  = wide_timer_on;
			rd_mux[`CTS_TC_WIDE_GE]  = wide_timer_gate_enable;
		end
		`CTS_OFF_SMALL_CNT: rd_mux[7:0]  = small_cnt;
		`CTS_OFF_WIDE_CNT:  rd_mux[15:0] = wide_cnt;
		`CTS_OFF_STATUS: begin
			rd_mux[0] = osc_source_sink_state;
			rd_mux[1] = osc_run;
			rd_mux[2] = noise_mode;
		end
		default:            rd_mux = 32'h0000_0000;
		endcase
	end

	always @(posedge mclk) begin
		if (srst) begin
			sense_unit_enable          <= RST_C1[`CTS_C1_ENABLE];
			reference_mode_bit         <= RST_C1[`CTS_C1_REFMODE];
			current_range_field        <= RST_C1[`CTS_C1_RNG_HI:`CTS_C1_RNG_LO];
			small_timer_ext_source_sel <= RST_C1[`CTS_C1_EXTSEL];
			sense_channel_select       <= RST_C2;
			small_timer_clock_source   <= RST_TC[`CTS_TC_SMALL_CS];
			wide_timer_clock_source    <= RST_TC[`CTS_TC_WIDE_CS_HI:`CTS_TC_WIDE_CS_LO];
			wide_timer_on              <= RST_TC[`CTS_TC_WIDE_ON];
			wide_timer_gate_enable     <= RST_TC[`CTS_TC_WIDE_GE];
			prdata                     <= 32'h0000_0000;
			pready                     <= 1'b0;
			pslverr                    <= 1'b0;
		end else begin
			// pready answers in the setup cycle's following edge
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !known;
			if (psel && !penable)
				prdata <= rd_mux;
			if (apb_wr && pready) begin
				case (paddr)
				`CTS_OFF_CTRL1: begin
					sense_unit_enable          <= pwdata[`CTS_C1_ENABLE];
					reference_mode_bit         <= pwdata[`CTS_C1_REFMODE];
					current_range_field        <= pwdata[`CTS_C1_RNG_HI:`CTS_C1_RNG_LO];
					small_timer_ext_source_sel <= pwdata[`CTS_C1_EXTSEL];
				end
				`CTS_OFF_CTRL2:
					sense_channel_select <= pwdata[CH_W-1:0];
				`CTS_OFF_TMR_CTRL: begin
					small_timer_clock_source <= pwdata[`CTS_TC_SMALL_CS];
					wide_timer_clock_source  <=
						pwdata[`CTS_TC_WIDE_CS_HI:`CTS_TC_WIDE_CS_LO];
					wide_timer_on            <= pwdata[`CTS_TC_WIDE_ON];
					wide_timer_gate_enable   <= pwdata[`CTS_TC_WIDE_GE];
				end
				default: ;
				endcase
			end
		end
	end
endmodule

// >>> hdl/cts_sync.v
`timescale 1ns/1ps
// Three-stage synchroniser; output changes once stages two and three agree
module cts_sync (
	input  wire mclk,
	input  wire srst,
	input  wire din,
	output reg  dout
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge mclk) begin
		if (srst) begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				dout <= s3;
		end
	end
endmodule

// >>> verif/cts_checker.sv
`timescale 1ns/1ps
module cts_checker #(
	parameter NUM_PADS = 16
) (
	input wire                mclk,
	input wire                srst,
	input wire                psel,
	input wire                penable,
	input wire                pready,
	input wire                pslverr,
	input wire [NUM_PADS-1:0] pad_connect,
	input wire                source_on,
	input wire                sink_on,
	input wire                comparators_on,
	input wire                ref_mode_variable,
	input wire [1:0]          current_range_out,
	input wire                small_timer_tick
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence setup_s;
		psel && !penable;
	endsequence
	// Two cycles, so a one-cycle skew between outputs is tolerated
	sequence noise_s;
		(ref_mode_variable && current_range_out == 2'h0) [*2];
	endsequence
	pad_onehot_a: assert property ($onehot0(pad_connect))
		else $error("pad select not one-hot");
	drive_excl_a: assert property (!(source_on && sink_on))
		else $error("source and sink together");
	noise_nodrive_a: assert property (noise_s |-> !source_on && !sink_on)
		else $error("pad current in noise mode");
	noise_comp_a: assert property (noise_s |-> comparators_on)
		else $error("comparators off in noise mode");
	apb_answer_a: assert property (setup_s |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	err_qual_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	tick_space_a: assert property (small_timer_tick |=> !small_timer_tick [*4])
		else $error("count edges too close");
endmodule

bind cts_sense cts_checker #(.NUM_PADS(NUM_PADS)) chk_u (.mclk, .srst, .psel, .penable,
	.pready, .pslverr, .pad_connect, .source_on, .sink_on, .comparators_on,
	.ref_mode_variable, .current_range_out, .small_timer_tick);

// >>> verif/cts_pad.sv
`timescale 1ns/1ps
module cts_pad (
	input wire        mclk,
	input wire        run,
	input wire        slow,
	input wire        noise,
	input wire        source_on,
	input wire        sink_on,
	output reg        comp_upper = 1'h0,
	output reg        comp_lower = 1'h0,
	output reg [31:0] periods = 32'h0
);
	reg [3:0] ramp = 4'h0;
	reg       sourcing = 1'h1;
	// Ramp stalls while run is low, or outside noise while neither drive is on
	always @(posedge mclk) begin
		if (run && noise) begin
			// Noise flips the comparators in turn, whatever the pad drive
			ramp <= ramp + 4'h1;
			if (ramp == 4'h7) begin
				comp_upper <= !comp_upper;
				comp_lower <= comp_upper;
				ramp <= 4'h0;
				if (comp_upper)
					periods <= periods + 32'h1;
			end
		end else if (run && source_on && !comp_upper) begin
			comp_lower <= 1'h0;
			ramp <= ramp + 4'h1;
			if (ramp == (slow ? 4'h9 : 4'h2)) begin
				comp_upper <= 1'h1;
				sourcing <= 1'h0;
				ramp <= 4'h0;
			end
		end else if (run && sink_on && !comp_lower) begin
			comp_upper <= 1'h0;
			ramp <= ramp + 4'h1;
			if (ramp == (slow ? 4'h9 : 4'h2)) begin
				comp_lower <= 1'h1;
				sourcing <= 1'h1;
				ramp <= 4'h0;
				periods <= periods + 32'h1;
			end
		end
	end
endmodule

// >>> verif/cts_sense_bench.sv
`timescale 1ns/1ps
`include "cts_consts.vh"
module cts_sense_bench;
	reg         mclk = 1'h0;
	reg         srst = 1'h1;
	reg         psel = 1'h0;
	reg         penable = 1'h0;
	reg         pwrite = 1'h0;
	reg  [11:0] paddr = 12'h0;
	reg  [31:0] pwdata = 32'h0;
	reg         cpu_sleep = 1'h0;
	reg         small_ext_pin = 1'h0;
	reg         wide_gate_in = 1'h0;
	reg         run = 1'h0;
	reg         slow = 1'h0;
	reg         noise = 1'h0;
	wire [31:0] prdata, periods;
	wire [15:0] pad_connect;
	wire [1:0]  current_range_out;
	wire        pready, pslverr, comp_upper, comp_lower, source_on, sink_on;
	wire        comparators_on, ref_mode_variable;
	wire        osc_enable, small_timer_tick, wide_timer_tick, small_overflow;
	int         fails = 0;
	int         n_tests = 0;
	int         cycles = 0;
	int         n_small = 0;
	int         n_wide = 0;
	int         d, ds, dw;
	always #2 mclk = ~mclk;
	cts_sense dut_u (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cpu_sleep, .comp_upper, .comp_lower, .small_ext_pin,
		.wide_gate_in, .pad_connect, .osc_enable, .source_on, .sink_on, .comparators_on,
		.ref_mode_variable, .current_range_out, .small_timer_tick, .wide_timer_tick,
		.small_overflow);
	cts_pad pad_u (.mclk, .run, .slow, .noise, .source_on, .sink_on, .comp_upper,
		.comp_lower, .periods);
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input [31:0] got, input [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Request stands until pready is seen high at a rising edge
	task automatic apb(input w, input [11:0] a, input [31:0] wd, output [31:0] r, output e);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input [11:0] a, input [31:0] wd);
		reg [31:0] r;
		reg        e;
		apb(1'h1, a, wd, r, e);
	endtask
	task automatic rd(input [11:0] a, input [31:0] exp);
		reg [31:0] r;
		reg        e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, exp);
		chk(e, a > 12'h014);
	endtask
	// Time base is the bench's own cycle count, not the counting timer
	task automatic measure(input [31:0] tc);
		int base;
		int sbase;
		int wbase;
		wr(`CTS_OFF_TMR_CTRL, tc | 32'h60);
		base = periods;
		sbase = n_small;
		wbase = n_wide;
		run <= 1'h1;
		repeat (200) @(posedge mclk);
		run <= 1'h0;
		repeat (20) @(posedge mclk);
		d = periods - base;
		ds = n_small - sbase;
		dw = n_wide - wbase;
	endtask
	task automatic s_reset;
		chk(pad_connect, 32'h0);
		rd(`CTS_OFF_CTRL1, 32'h2);
		rd(12'h020, 32'h0);
	endtask
	task automatic s_modes;
		for (int i = 0; i < 8; i++) begin
			wr(`CTS_OFF_CTRL1, 32'h80 | (i[2] << 6) | (i[1:0] << 2));
			repeat (3) @(posedge mclk);
			chk(ref_mode_variable, i[2]);
			chk(current_range_out, i[1:0]);
			chk(osc_enable, i != 0);
			if (i == 0) chk({source_on, sink_on}, 32'h0);
			if (i == 0) rd(`CTS_OFF_STATUS, 32'h1);
			if (i == 4) chk({source_on, sink_on, comparators_on}, 32'h1);
			if (i == 4) rd(`CTS_OFF_STATUS, 32'h7);
		end
	endtask
	task automatic s_channels;
		for (int ch = 0; ch < 16; ch++) begin
			wr(`CTS_OFF_CTRL2, ch);
			repeat (2) @(posedge mclk);
			chk(pad_connect, 32'h1 << ch);
		end
		wr(`CTS_OFF_CTRL1, 32'h0C);
		repeat (2) @(posedge mclk);
		chk(pad_connect, 32'h0);
	endtask
	task automatic s_small;
		wr(`CTS_OFF_CTRL1, 32'h8D);
		measure(32'h0);
		rd(`CTS_OFF_SMALL_CNT, d);
		chk(ds, d);
		rd(`CTS_OFF_WIDE_CNT, 32'h0);
		rd(`CTS_OFF_CTRL1, 32'h8D | (pad_u.sourcing ? 32'h2 : 32'h0));
	endtask
	task automatic s_wide;
		slow <= 1'h1;
		wr(`CTS_OFF_CTRL1, 32'h8C);
		measure(32'h0F);
		rd(`CTS_OFF_WIDE_CNT, d);
		chk(dw, d);
		rd(`CTS_OFF_SMALL_CNT, 32'h0);
		measure(32'h06);
		rd(`CTS_OFF_WIDE_CNT, 32'h0);
		measure(32'h1E);
		rd(`CTS_OFF_WIDE_CNT, 32'h0);
		wide_gate_in <= 1'h1;
		measure(32'h1E);
		rd(`CTS_OFF_WIDE_CNT, d);
	endtask
	task automatic s_sleep;
		wr(`CTS_OFF_CTRL1, 32'h8D);
		cpu_sleep <= 1'h1;
		measure(32'h0E);
		rd(`CTS_OFF_SMALL_CNT, 32'h0);
		rd(`CTS_OFF_WIDE_CNT, d);
		cpu_sleep <= 1'h0;
	endtask
	task automatic s_noise;
		noise <= 1'h1;
		wr(`CTS_OFF_CTRL1, 32'hC0);
		measure(32'h0E);
		rd(`CTS_OFF_WIDE_CNT, d);
		chk(d > 0, 1);
		chk(dw, d);
		noise <= 1'h0;
	endtask
	// Small timer on pin edges; its overflow toggles the wide gate
	task automatic s_pin;
		int ovf;
		int sbase;
		ovf = 0;
		wr(`CTS_OFF_TMR_CTRL, 32'h61);
		sbase = n_small;
		for (int k = 0; k < 2060; k++) begin
			@(posedge mclk);
			small_ext_pin <= (k < 2048) && k[2];
			if (small_overflow === 1'h1) begin
				ovf++;
				wide_gate_in <= ~wide_gate_in;
			end
		end
		chk(ovf, 1);
		chk(n_small - sbase, 256);
		rd(`CTS_OFF_SMALL_CNT, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		srst <= 1'h0;
		s_reset;
		s_modes;
		s_channels;
		s_small;
		s_wide;
		s_sleep;
		s_noise;
		s_pin;
		final_report;
	end
	always @(posedge mclk) begin
		cycles++;
		if (small_timer_tick === 1'h1)
			n_small++;
		if (wide_timer_tick === 1'h1)
			n_wide++;
		if (cycles == 20000) begin
			fails++;
			final_report;
		end
	end
endmodule
